// [logic/bpsp_gpio_port.sv]
// bpsp_gpio_port: four bidirectional 8-bit ports with shared pin functions, APB slave.
// assumes pins synchronous to pclk, an APB3 master and external pfd, timer and lcd logic.
// Overview of operation
// [RL1] direction one: pin is input, read pin
// [RL2] direction zero: push-pull output from latch
// [RL3] output pin reads back its latch
// [RL4] direction writes take effect at once
// [RL5] direction written as byte or per bit
// [RL6] reset sets all latches and directions
// [RL7] new output drives high after reset
// [RL8] bit ops read, modify, write whole port
// [RL9] external interrupt only from input pin
// [RL10] interrupt pin keeps read and pull-up
// [RL11] timer pin feeds counter in count modes
// [RL12] timer pin keeps read and pull-up
// [RL13] divider output needs select and output
// [RL14] divider selected on input: ordinary input
// [RL15] four port B pins drive half bias
// [RL16] sleep wake on enabled port A fall
// [RL17] pull-up only when set and input
// [RL18] port A top pull-up absent, reads zero
// [RL19] read samples pins, inputs not latched
// [RL20] wake input synchronised, one wake pulse
//
// The placing of the registers and the APB slave port are this design's own decisions.
module bpsp_gpio_port
    import bpsp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pads
    input wire logic [NPORT-1:0][PW-1:0] pin_i,
    output bpsp_pad_t [NPORT-1:0] pad_o,
    output logic [LCD_PINS-1:0] lcd_common_driver_o,
    // shared functions
    input wire logic freq_divider_i,
    output logic irq_ext_o,
    output logic irq_ext_enable_o,
    output logic timer_event_pin_zero,
    output logic timer_event_pin_one,
    output logic timer_event_pin_two,
    output logic [NTIMER*TMODE_W-1:0] timer_mode_o,
    // power
    input wire logic sleep_i,
    output logic wake_req_o
);

    function automatic logic [7:0] port_addr(input int n, input logic [7:0] ofs);
        port_addr = (8'(n) * PORT_STRIDE) + ofs;
    endfunction : port_addr

    function automatic logic [7:0] bitop_addr(input int n, input logic [7:0] ofs);
        bitop_addr = BITOP_BASE + (8'(n) * PORT_STRIDE) + ofs;
    endfunction : bitop_addr

    // bus phases
    logic setup;
    logic acc;
    logic wr_en;
    logic addr_ok;
    assign setup = psel & ~penable;
    assign acc = psel & penable;
    assign wr_en = acc & pwrite;

    // storage
    logic [NPORT-1:0][PW-1:0] data_q;
    logic [NPORT-1:0][PW-1:0] data_d;
    logic [NPORT-1:0][PW-1:0] dir_q;
    logic [NPORT-1:0][PW-1:0] dir_d;
    logic [NPORT-1:0][PW-1:0] pu_q;
    logic [NPORT-1:0][PW-1:0] pu_d;
    logic [PW-1:0] wake_q;
    logic [PW-1:0] wake_d;
    logic [PW-1:0] irqc_q;
    logic [PW-1:0] irqc_d;
    logic [PW-1:0] sysc_q;
    logic [PW-1:0] sysc_d;
    logic [PW-1:0] lcdc_q;
    logic [PW-1:0] lcdc_d;
    logic [PW-1:0] tmode_q;
    logic [PW-1:0] tmode_d;
    logic [PW-1:0] rdata_q;
    logic [PW-1:0] rd_byte;

    // decode
    logic [NPORT-1:0] hit_data;
    logic [NPORT-1:0] hit_dir;
    logic [NPORT-1:0] hit_pu;
    logic [NPORT-1:0] hit_dset;
    logic [NPORT-1:0] hit_dclr;
    logic [NPORT-1:0] hit_rset;
    logic [NPORT-1:0] hit_rclr;
    logic hit_wake;
    logic hit_irqc;
    logic hit_sysc;
    logic hit_lcdc;
    logic hit_tmode;
    logic [NPORT-1:0][PW-1:0] port_val;
    logic [PW-1:0] wbyte;

    assign wbyte = pwdata[PW-1:0];
    assign hit_wake = (paddr == port_addr(PORT_A, OFS_WAKE));
    assign hit_irqc = (paddr == ADDR_IRQ_CONTROL_ZERO);
    assign hit_sysc = (paddr == ADDR_SYSTEM_CONTROL_ZERO);
    assign hit_lcdc = (paddr == ADDR_LCD_COMMON_CONTROL);
    assign hit_tmode = (paddr == ADDR_TIMER_MODE);

    genvar n;
    generate
        for (n = 0; n < NPORT; n++)
        begin : g_port
            localparam logic [PW-1:0] PU_MASK = (n == PORT_A) ? PU_MASK_A : PU_MASK_OTHER;

            assign hit_data[n] = (paddr == port_addr(n, OFS_DATA));
            assign hit_dir[n] = (paddr == port_addr(n, OFS_DIR));
            assign hit_pu[n] = (paddr == port_addr(n, OFS_PU));
            assign hit_dset[n] = (paddr == bitop_addr(n, OFS_DATA_SET));
            assign hit_dclr[n] = (paddr == bitop_addr(n, OFS_DATA_CLR));
            assign hit_rset[n] = (paddr == bitop_addr(n, OFS_DIR_SET));
            assign hit_rclr[n] = (paddr == bitop_addr(n, OFS_DIR_CLR));

            // inputs are never latched: a read sees the pin itself
            assign port_val[n] = (dir_q[n] & pin_i[n]) | (~dir_q[n] & data_q[n]); // RL1 RL3 RL19

            // bit ops act on the value a port read would return, so input
            // pins load their present level into the latch
            always_comb
            begin
                data_d[n] = data_q[n];
                if (wr_en && hit_data[n])
                    data_d[n] = wbyte;
                else if (wr_en && hit_dset[n])
                    data_d[n] = port_val[n] | wbyte; // RL8
                else if (wr_en && hit_dclr[n])
                    data_d[n] = port_val[n] & ~wbyte; // RL8
            end

            always_comb
            begin
                dir_d[n] = dir_q[n];
                if (wr_en && hit_dir[n])
                    dir_d[n] = wbyte; // RL5
                else if (wr_en && hit_rset[n])
                    dir_d[n] = dir_q[n] | wbyte; // RL5
                else if (wr_en && hit_rclr[n])
                    dir_d[n] = dir_q[n] & ~wbyte; // RL5
            end

            assign pu_d[n] = (wr_en && hit_pu[n]) ? (wbyte & PU_MASK) : pu_q[n]; // RL18

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    data_q[n] <= DATA_RST; // RL6 RL7
                    dir_q[n] <= DIR_RST; // RL6
                    pu_q[n] <= PU_RST;
                end
                else
                begin
                    data_q[n] <= data_d[n];
                    dir_q[n] <= dir_d[n]; // RL4
                    pu_q[n] <= pu_d[n];
                end
            end
        end
    endgenerate

    assign wake_d = (wr_en && hit_wake) ? wbyte : wake_q;
    assign irqc_d = (wr_en && hit_irqc) ? wbyte : irqc_q;
    assign sysc_d = (wr_en && hit_sysc) ? wbyte : sysc_q;
    assign lcdc_d = (wr_en && hit_lcdc) ? wbyte : lcdc_q;
    assign tmode_d = (wr_en && hit_tmode) ? wbyte : tmode_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_q <= WAKE_RST;
            irqc_q <= CTRL_RST;
            sysc_q <= CTRL_RST;
            lcdc_q <= CTRL_RST;
            tmode_q <= CTRL_RST;
        end
        else
        begin
            wake_q <= wake_d;
            irqc_q <= irqc_d;
            sysc_q <= sysc_d;
            lcdc_q <= lcdc_d;
            tmode_q <= tmode_d;
        end
    end

    // read mux; bit-op addresses are write-only and read zero
    assign addr_ok = (|hit_data) | (|hit_dir) | (|hit_pu) | (|hit_dset) | (|hit_dclr) | (|hit_rset)
        | (|hit_rclr) | hit_wake | hit_irqc | hit_sysc | hit_lcdc | hit_tmode;

    always_comb
    begin
        rd_byte = '0;
        for (int k = 0; k < NPORT; k++)
        begin
            if (hit_data[k])
                rd_byte = port_val[k]; // RL1 RL3
            if (hit_dir[k])
                rd_byte = dir_q[k];
            if (hit_pu[k])
                rd_byte = pu_q[k]; // RL18
        end
        if (hit_wake)
            rd_byte = wake_q;
        if (hit_irqc)
            rd_byte = irqc_q;
        if (hit_sysc)
            rd_byte = sysc_q;
        if (hit_lcdc)
            rd_byte = lcdc_q;
        if (hit_tmode)
            rd_byte = tmode_q;
    end

    // pins are sampled in the setup cycle, the first phase of a read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_q <= '0;
        else if (setup && !pwrite)
            rdata_q <= rd_byte; // RL19
    end

    assign prdata = {{(32 - PW){1'b0}}, rdata_q};
    assign pready = 1'b1;
    assign pslverr = acc & ~addr_ok;

    // pad drive
    logic pfd_sel;
    assign pfd_sel = sysc_q[PFD_SEL_BIT];

    genvar p;
    genvar b;
    generate
        for (p = 0; p < NPORT; p++)
        begin : g_pad
            for (b = 0; b < PW; b++)
            begin : g_bit
                localparam bit IS_PFD = (p == PFD_PORT) && (b == PFD_BIT);
                localparam bit IS_LCD = (p == LCD_PORT) && (b < LCD_PINS);
                logic lcd_on;
                if (IS_LCD)
                begin : g_lcd
                    // a common pin left as input sits at half bias; as output it drives the select level
                    assign lcd_on = lcdc_q[b] & dir_q[p][b]; // RL15
                    assign lcd_common_driver_o[b] = lcd_on; // RL15
                end
                else
                begin : g_nolcd
                    assign lcd_on = 1'b0;
                end
                if (IS_PFD)
                begin : g_pfd
                    // divider output only when also an output; otherwise a normal input
                    assign pad_o[p].o[b] = pfd_sel ? freq_divider_i : data_q[p][b]; // RL13 RL14
                end
                else
                begin : g_plain
                    assign pad_o[p].o[b] = data_q[p][b]; // RL2 RL7
                end
                assign pad_o[p].oe[b] = ~dir_q[p][b]; // RL2 RL4
                // pull-up dropped on half-bias pins so the bias divider is not skewed
                assign pad_o[p].pu[b] = pu_q[p][b] & dir_q[p][b] & ~lcd_on; // RL17 RL10 RL12 RL14
            end
        end
    endgenerate

    // external interrupt pin; read path and pull-up stay as for any input
    assign irq_ext_o = dir_q[EXT_INT_PORT][EXT_INT_BIT] ? pin_i[EXT_INT_PORT][EXT_INT_BIT] : EXT_INT_IDLE; // RL9 RL10
    assign irq_ext_enable_o = irqc_q[EXT_EN_BIT]; // RL9

    // timer event inputs
    logic [NTIMER-1:0] tc_pin;
    genvar t;
    generate
        for (t = 0; t < NTIMER; t++)
        begin : g_tc
            bpsp_tmode_t mode;
            logic count_mode;
            assign mode = bpsp_tmode_t'(tmode_q[t*TMODE_W +: TMODE_W]);
            assign count_mode = (mode == BPSP_TM_EVENT) || (mode == BPSP_TM_CAPTURE);
            assign tc_pin[t] = count_mode & dir_q[TC_PORT[t]][TC_BIT[t]] & pin_i[TC_PORT[t]][TC_BIT[t]]; // RL11 RL12
        end
    endgenerate

    assign timer_event_pin_zero = tc_pin[0];
    assign timer_event_pin_one = tc_pin[1];
    assign timer_event_pin_two = tc_pin[2];
    assign timer_mode_o = tmode_q[NTIMER*TMODE_W-1:0];

    // wake-up from port A
    bpsp_wake_detect u_wake (
        .pclk(pclk),
        .presetn(presetn),
        .pin_i(pin_i[PORT_A]),
        .enable_i(wake_q),
        .sleep_i(sleep_i),
        .wake_req_o(wake_req_o)
    ); // RL16 RL20

endmodule : bpsp_gpio_port

// [logic/bpsp_pkg.sv]
// bpsp_pkg: constants, register map and types of the bidirectional port block.
// assumes a 100 MHz pclk, an APB3 master and pad cells that take o, oe and pull-up enables.
package bpsp_pkg;

    // port geometry
    localparam int PW = 8;
    localparam int NPORT = 4;
    localparam int APB_AW = 8;
    localparam int NTIMER = 3;
    localparam int LCD_PINS = 4;

    // port index of each port
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;

    // per-port register block: base is n * stride
    localparam logic [7:0] PORT_STRIDE = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_PU = 8'h08;
    localparam logic [7:0] OFS_WAKE = 8'h0c;

    // single-register block
    localparam logic [7:0] ADDR_IRQ_CONTROL_ZERO = 8'h40;
    localparam logic [7:0] ADDR_SYSTEM_CONTROL_ZERO = 8'h44;
    localparam logic [7:0] ADDR_LCD_COMMON_CONTROL = 8'h48;
    localparam logic [7:0] ADDR_TIMER_MODE = 8'h4c;

    // bit set/clear block, one group per port at BITOP_BASE + n * stride
    localparam logic [7:0] BITOP_BASE = 8'h80;
    localparam logic [7:0] OFS_DATA_SET = 8'h00;
    localparam logic [7:0] OFS_DATA_CLR = 8'h04;
    localparam logic [7:0] OFS_DIR_SET = 8'h08;
    localparam logic [7:0] OFS_DIR_CLR = 8'h0c;

    // values after reset
    localparam logic [PW-1:0] DATA_RST = 8'hff;
    localparam logic [PW-1:0] DIR_RST = 8'hff;
    localparam logic [PW-1:0] PU_RST = 8'h00;
    localparam logic [PW-1:0] WAKE_RST = 8'h00;
    localparam logic [PW-1:0] CTRL_RST = 8'h00;
    localparam logic [PW-1:0] SYNC_RST = 8'hff;

    // port A top pin has no pull-high control
    localparam logic [PW-1:0] PU_MASK_A = 8'h7f;
    localparam logic [PW-1:0] PU_MASK_OTHER = 8'hff;

    // shared pin placement
    localparam int EXT_INT_PORT = PORT_A;
    localparam int EXT_INT_BIT = 3;
    localparam int TC_PORT [0:NTIMER-1] = '{PORT_A, PORT_A, PORT_C};
    localparam int TC_BIT [0:NTIMER-1] = '{4, 5, 0};
    localparam int PFD_PORT = PORT_B;
    localparam int PFD_BIT = 5;
    localparam int LCD_PORT = PORT_B;

    // control field positions
    localparam int EXT_EN_BIT = 0;
    localparam int PFD_SEL_BIT = 0;
    localparam int TMODE_W = 2;
    localparam logic EXT_INT_IDLE = 1'b1;

    typedef enum logic [1:0] {
        BPSP_TM_NONE = 2'b00,
        BPSP_TM_EVENT = 2'b01,
        BPSP_TM_TIMER = 2'b10,
        BPSP_TM_CAPTURE = 2'b11
    } bpsp_tmode_t;

    // drive of one port toward its pads
    typedef struct packed {
        logic [PW-1:0] o;
        logic [PW-1:0] oe;
        logic [PW-1:0] pu;
    } bpsp_pad_t;

endpackage : bpsp_pkg

// [logic/bpsp_wake_detect.sv]
// bpsp_wake_detect: falling-edge wake detector for port A.
// assumes pins may change at any time; each pin is resynchronised before use.
module bpsp_wake_detect
    import bpsp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins and controls
    input wire logic [PW-1:0] pin_i,
    input wire logic [PW-1:0] enable_i,
    input wire logic sleep_i,
    // power controller
    output logic wake_req_o
);

    logic [PW-1:0] sync1_q;
    logic [PW-1:0] sync2_q;
    logic [PW-1:0] prev_q;
    logic [PW-1:0] fall;
    logic wake_req_q;

    // reset to high so a pin idling high raises no edge at release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
            prev_q <= SYNC_RST;
        end
        else
        begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    genvar b;
    generate
        for (b = 0; b < PW; b++)
        begin : g_fall
            assign fall[b] = enable_i[b] & prev_q[b] & ~sync2_q[b]; // RL16 RL20
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_req_o_reset: wake_req_q <= 1'b0;
        else
            wake_req_q <= sleep_i & (|fall); // RL16
    end

    assign wake_req_o = wake_req_q;

endmodule : bpsp_wake_detect

// [test/bpsp_properties.sv]
// bpsp_properties: concurrent checks on the ports of bpsp_gpio_port.
// assumes zero-wait apb and pads that follow the registers in the same cycle.
module bpsp_properties
    import bpsp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // pads and shared functions
    input wire logic [NPORT-1:0][PW-1:0] pin_i,
    input wire bpsp_pad_t [NPORT-1:0] pad_o,
    input wire logic [LCD_PINS-1:0] lcd_common_driver_o,
    input wire logic irq_ext_o,
    input wire logic timer_event_pin_zero,
    input wire logic [NTIMER*TMODE_W-1:0] timer_mode_o,
    input wire logic sleep_i,
    input wire logic wake_req_o
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc;
    assign acc = psel & penable;

    a_dir_write: assert property (acc & pwrite & paddr == OFS_DIR |=> ~pad_o[0].oe == $past(pwdata[7:0]))
        else $error("port a drive differs from written direction");
    a_read_pin: assert property (acc & !pwrite & paddr == OFS_DATA |->
        (prdata[7:0] & ~pad_o[0].oe) == ($past(pin_i[0]) & ~pad_o[0].oe) && prdata[31:8] == 24'h0)
        else $error("input pins not read at setup");
    a_read_latch: assert property (acc & !pwrite & paddr == OFS_DATA |->
        (prdata[7:0] & pad_o[0].oe) == (pad_o[0].o & pad_o[0].oe))
        else $error("output pins not read from latch");
    a_irq_path: assert property (irq_ext_o == (pad_o[0].oe[3] | pin_i[0][3]))
        else $error("interrupt input not gated by direction");
    a_timer_gate: assert property (timer_event_pin_zero == (timer_mode_o[0] & ~pad_o[0].oe[4] & pin_i[0][4]))
        else $error("timer pin gating wrong");
    a_pu_inputs: assert property ((pad_o[0].pu & pad_o[0].oe) == 8'h00 && (pad_o[1].pu & pad_o[1].oe) == 8'h00)
        else $error("pull-up on an output pin");
    a_pa7_pu: assert property (!pad_o[0].pu[7])
        else $error("pull-up on port a top pin");
    a_lcd_input: assert property (lcd_common_driver_o != 4'h0 |-> (lcd_common_driver_o & pad_o[1].oe[3:0]) == 4'h0)
        else $error("common driver on a driven pin");
    a_wake_single: assert property (wake_req_o |=> !wake_req_o)
        else $error("wake request longer than one cycle");
    a_wake_cause: assert property (wake_req_o |-> $past(sleep_i) && |($past(pin_i[0], 4) & ~$past(pin_i[0], 3)))
        else $error("wake request without falling pin");
    a_reset_dir: assert property ($rose(presetn) |-> pad_o[0].oe == 8'h00 && pad_o[3].o == 8'hff)
        else $error("pads not input after reset");

    c_dir_write: cover property (acc & pwrite & paddr == OFS_DIR);
    c_wake: cover property (wake_req_o);
    c_lcd: cover property (lcd_common_driver_o == 4'hf);
endmodule : bpsp_properties

bind bpsp_gpio_port bpsp_properties bpsp_properties_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pin_i, .pad_o, .lcd_common_driver_o, .irq_ext_o, .timer_event_pin_zero, .timer_mode_o, .sleep_i,
    .wake_req_o);

// [test/bpsp_board.sv]
// bpsp_board: board circuitry around the four ports.
// assumes the bench decides which lines an outside driver holds.
module bpsp_board
    import bpsp_pkg::*;
(
    // clock
    input wire logic pclk,
    // pads and outside drivers
    input wire bpsp_pad_t [NPORT-1:0] pad_o,
    input wire logic [NPORT-1:0][PW-1:0] ext_en,
    input wire logic [NPORT-1:0][PW-1:0] ext_v,
    output logic [NPORT-1:0][PW-1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flt_q = 1'b0;
    // a floating line wanders, so a stale level is never read back
    always @(posedge pclk) flt_q <= ~flt_q;
    // a strong outside driver wins over the pad, so read-back of the latch shows
    always_comb
    begin
        for (int n = 0; n < NPORT; n++)
            pin_o[n] = (ext_en[n] & ext_v[n]) | (~ext_en[n] & ((pad_o[n].oe & pad_o[n].o)
                | (~pad_o[n].oe & (pad_o[n].pu | {PW{flt_q}}))));
    end
endmodule : bpsp_board

// [test/tb_top.sv]
// tb_top: self-checking bench for bpsp_gpio_port over apb.
// assumes bpsp_board drives the pins and the checker is bound to the design.
module tb_top
    import bpsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, freq_divider_i, sleep_i;
    logic irq_ext_o, irq_ext_enable_o, timer_event_pin_zero, timer_event_pin_one, timer_event_pin_two, wake_req_o;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic err_q;
    logic [NPORT-1:0][PW-1:0] pin_i, ext_en, ext_v;
    bpsp_pad_t [NPORT-1:0] pad_o;
    logic [3:0] lcd_common_driver_o;
    logic [5:0] timer_mode_o;
    int miscompares = 0;
    int checks = 0;

    bpsp_gpio_port bpsp_gpio_port_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pin_i, .pad_o, .lcd_common_driver_o, .freq_divider_i, .irq_ext_o, .irq_ext_enable_o,
        .timer_event_pin_zero, .timer_event_pin_one, .timer_event_pin_two, .timer_mode_o, .sleep_i, .wake_req_o);
    bpsp_board bpsp_board_i (.pclk, .pad_o, .ext_en, .ext_v, .pin_o(pin_i));

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so callers see settled pads and drive on a rising edge
        @(posedge pclk);
    endtask : apb

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic t_reset();
        for (int n = 0; n < NPORT; n++)
        begin
            apb(0, PORT_STRIDE * 8'(n) + OFS_DIR, 0);
            chk("dir", rd_q, 32'hff);
            apb(0, PORT_STRIDE * 8'(n) + OFS_PU, 0);
            chk("pu", rd_q, 32'h0);
            chk("oe", {24'h0, pad_o[n].oe}, 32'h0);
        end
        apb(0, 8'h50, 0);
        chk("unmapped", {31'h0, err_q}, 32'h1);
        apb(1, OFS_PU, 8'hff);
        apb(0, OFS_PU, 0);
        chk("pu a", rd_q, 32'h7f);
        apb(1, OFS_PU, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_output();
        ext_en[0] <= 8'hff;
        ext_v[0] <= 8'h3c;
        apb(1, OFS_DIR, 8'hf0);
        chk("oe", {24'h0, pad_o[0].oe}, 32'h0f);
        chk("o", {24'h0, pad_o[0].o}, 32'hff);
        apb(0, OFS_DATA, 0);
        chk("rd mix", rd_q, 32'h3f);
        apb(1, OFS_DATA, 8'h05);
        chk("o", {24'h0, pad_o[0].o}, 32'h05);
        apb(0, OFS_DATA, 0);
        chk("rd mix", rd_q, 32'h35);
        apb(1, OFS_DIR, 8'hff);
        $display("test output done");
    endtask : t_output

    task automatic t_bitops();
        ext_v[0] <= 8'ha5;
        apb(1, BITOP_BASE + OFS_DATA_CLR, 8'h01);
        apb(1, BITOP_BASE + OFS_DIR_CLR, 8'h0f);
        chk("oe", {24'h0, pad_o[0].oe}, 32'h0f);
        chk("o", {24'h0, pad_o[0].o}, 32'ha4);
        ext_en[0] <= 8'h00;
        apb(1, BITOP_BASE + OFS_DATA_SET, 8'h02);
        chk("o low", {28'h0, pad_o[0].o[3:0]}, 32'h6);
        apb(1, BITOP_BASE + OFS_DIR_SET, 8'hff);
        chk("oe", {24'h0, pad_o[0].oe}, 32'h0);
        $display("test bitops done");
    endtask : t_bitops

    task automatic t_shared();
        ext_en[0] <= 8'hff;
        ext_v[0] <= 8'h00;
        apb(1, OFS_PU, 8'h08);
        chk("irq", {31'h0, irq_ext_o}, 32'h0);
        chk("pu3", {31'h0, pad_o[0].pu[3]}, 32'h1);
        apb(1, OFS_DIR, 8'hf7);
        chk("irq", {31'h0, irq_ext_o}, 32'h1);
        apb(1, OFS_DIR, 8'hff);
        apb(1, ADDR_IRQ_CONTROL_ZERO, 8'h01);
        chk("irq en", {31'h0, irq_ext_enable_o}, 32'h1);
        ext_v[0] <= 8'h10;
        for (int m = 0; m < 4; m++)
        begin
            apb(1, ADDR_TIMER_MODE, 8'(m));
            chk("tmode", {26'h0, timer_mode_o}, 32'(m));
            chk("tc0", {31'h0, timer_event_pin_zero}, 32'(m % 2));
        end
        ext_v[0] <= 8'h30;
        ext_en[2] <= 8'hff;
        ext_v[2] <= 8'h01;
        apb(1, ADDR_TIMER_MODE, 8'h34);
        chk("tc1", {31'h0, timer_event_pin_one}, 32'h1);
        chk("tc2", {31'h0, timer_event_pin_two}, 32'h1);
        chk("tc0 none", {31'h0, timer_event_pin_zero}, 32'h0);
        apb(0, OFS_DATA, 0);
        chk("tc rd", rd_q, 32'h30);
        apb(1, ADDR_TIMER_MODE, 8'h01);
        apb(1, OFS_DIR, 8'hef);
        chk("tc0 out", {31'h0, timer_event_pin_zero}, 32'h0);
        apb(1, OFS_DIR, 8'hff);
        apb(1, ADDR_SYSTEM_CONTROL_ZERO, 8'h01);
        apb(1, PORT_STRIDE + OFS_PU, 8'hff);
        apb(1, PORT_STRIDE + OFS_DIR, 8'hdf);
        for (int v = 0; v < 2; v++)
        begin
            freq_divider_i <= v[0];
            @(posedge pclk);
            chk("pfd", {31'h0, pad_o[1].o[5]}, 32'(v));
        end
        apb(1, PORT_STRIDE + OFS_DIR, 8'hff);
        chk("pfd in", {30'h0, pad_o[1].oe[5], pad_o[1].pu[5]}, 32'h1);
        apb(1, ADDR_LCD_COMMON_CONTROL, 8'h0f);
        chk("lcd", {28'h0, lcd_common_driver_o}, 32'hf);
        chk("lcd pu", {24'h0, pad_o[1].pu}, 32'hf0);
        $display("test shared done");
    endtask : t_shared

    task automatic t_wake(input logic slp, input int exp);
        int cnt;
        cnt = 0;
        ext_en[0] <= 8'hff;
        ext_v[0] <= 8'hff;
        apb(1, OFS_WAKE, 8'h04);
        sleep_i <= slp;
        repeat (4) @(posedge pclk);
        ext_v[0] <= 8'hf3;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge pclk);
            if (wake_req_o === 1'b1)
                cnt++;
        end
        chk("wake", 32'(cnt), 32'(exp));
        $display("test wake done");
    endtask : t_wake

    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    initial
    begin
        #50us;
        miscompares++;
        test_done();
    end

    initial
    begin
        {psel, penable, pwrite, freq_divider_i, sleep_i} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_en = '0;
        ext_v = '0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_output();
        t_bitops();
        t_shared();
        t_wake(1'b1, 1);
        t_wake(1'b0, 0);
        test_done();
    end
endmodule : tb_top
